// ---- rtl/ees_slave.sv ----
/*
  Two-wire serial slave front end of a 512 x 8 EEPROM.
  Assumes a memory controller on clk_sys that takes write events,
  answers read requests in the same cycle that mem_rd_en is high and reports its write
  cycle on wr_busy. Each SCL phase must last at least 16 clk_link
  cycles so that read data crosses in time.
*/
// Operation
// R01 - Sample on SCL rise, drive on fall
// R02 - MSB first, eight bits plus acknowledge
// R03 - Master clocks every bit without gaps
// R04 - SDA changes only while SCL low
// R05 - SDA fall with SCL high starts
// R06 - Ignore the bus until a start
// R07 - SDA rise with SCL high stops
// R08 - Repeated start begins a new command
// R09 - No limit on bytes per transfer
// R10 - Idle needs both lines high
// R11 - Receiver holds SDA low during ack
// R12 - Receiver releases SDA after ninth clock
// R13 - Master NACK ends device transmission
// R14 - Standby on reset, stop, mismatch, NACK
// R15 - Master recovers bus with start, clocks, stop
// R16 - Memory is 32 pages of 16 bytes
// R17 - Upper nibble compared against type identifier
// R18 - Bits 3 and 2 match the straps
// R19 - Bit 1 is memory address top bit
// R20 - Bit 0 selects read or write
// R21 - Acknowledge on match, else standby
// R22 - Second byte holds low address bits
// R23 - No acknowledge while write in progress
// R24 - Writes advance only the page offset
// R25 - Synchronise and filter SCL and SDA
`timescale 1ns/1ps
module ees_slave #(
  parameter int unsigned FILT_LEN    = ees_pkg::FILT_LEN_DEF,
  // Arbitrary value
  parameter logic [3:0]  DEV_TYPE_ID = 4'h6
) (
  // System clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // Two-wire link
  input  wire logic                          clk_link,
  input  wire logic                          scl_i,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe_n,
  // Address straps
  input  wire logic                          strap_addr_hi,
  input  wire logic                          strap_addr_lo,
  // Memory side
  input  wire logic                          wr_busy,
  output logic                               ev_valid,
  output ees_pkg::ees_ev_s                   ev,
  output logic                               mem_rd_en,
  output logic [ees_pkg::MEM_AW-1:0]         mem_rd_addr,
  input  wire logic [7:0]                    mem_rd_data,
  output logic                               standby
);

  localparam int CW = $clog2(FILT_LEN + 1);
  localparam int SCL = ees_pkg::LN_SCL;
  localparam int SDA = ees_pkg::LN_SDA;

  function automatic logic dev_match(input logic [7:0] b, input logic [1:0] strap);
    // R17 type identifier
    // R18 strap bits
    return (b[ees_pkg::DA_ID_HI:ees_pkg::DA_ID_LO] == DEV_TYPE_ID) &&
           (b[ees_pkg::DA_STRAP_HI:ees_pkg::DA_STRAP_LO] == strap);
  endfunction : dev_match

  // ----------------------------------------
  // Link input synchronisers and filter
  // ----------------------------------------
  logic [1:0]          pin_s1_reg;
  logic [1:0]          pin_s2_reg;
  logic [1:0]          filt_reg;
  logic [1:0]          filt_d_reg;
  logic [1:0][CW-1:0]  fcnt_reg;
  logic [2:0]          cfg_s1_reg;
  logic [2:0]          cfg_s2_reg;

  // R25 two-flop sync
  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      pin_s1_reg <= ees_pkg::LINES_IDLE;
      pin_s2_reg <= ees_pkg::LINES_IDLE;
      cfg_s1_reg <= '0;
      cfg_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {sda_i, scl_i};
      pin_s2_reg <= pin_s1_reg;
      cfg_s1_reg <= {wr_busy, strap_addr_hi, strap_addr_lo};
      cfg_s2_reg <= cfg_s1_reg;
    end
  end

  // R25 glitch filter
  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      filt_reg   <= ees_pkg::LINES_IDLE;
      filt_d_reg <= ees_pkg::LINES_IDLE;
      fcnt_reg   <= '0;
    end else begin
      filt_d_reg <= filt_reg;
      for (int i = 0; i < 2; i++) begin
        if (pin_s2_reg[i] == filt_reg[i]) begin
          fcnt_reg[i] <= '0;
        end else if (fcnt_reg[i] == CW'(FILT_LEN - 1)) begin
          filt_reg[i] <= pin_s2_reg[i];
          fcnt_reg[i] <= '0;
        end else begin
          fcnt_reg[i] <= fcnt_reg[i] + CW'(1);
        end
      end
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic scl_hi;
  logic busy_l;

  assign scl_rise = filt_reg[SCL] & ~filt_d_reg[SCL];
  assign scl_fall = ~filt_reg[SCL] & filt_d_reg[SCL];
  assign scl_hi   = filt_reg[SCL] & filt_d_reg[SCL];
  // R05 start edge
  // R10 line levels
  assign start_det = scl_hi & filt_d_reg[SDA] & ~filt_reg[SDA];
  // R07 stop edge
  assign stop_det  = scl_hi & ~filt_d_reg[SDA] & filt_reg[SDA];
  assign busy_l    = cfg_s2_reg[2];

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  ees_pkg::ees_state_e          state_reg;
  ees_pkg::ees_phase_e          phase_reg;
  // R16 page and offset split
  logic [3:0]                   bit_cnt_reg;
  logic [7:0]                   shift_reg;
  logic [ees_pkg::MEM_AW-1:0]   addr_reg;
  logic                         rnw_reg;
  logic                         pull_reg;
  logic                         wr_pend_reg;
  logic [7:0]                   rd_byte_reg;
  logic                         rd_req_tgl_reg;
  logic [ees_pkg::MEM_AW-1:0]   rd_addr_hold_reg;
  logic                         ev_tgl_reg;
  ees_pkg::ees_ev_s             ev_hold_reg;
  logic                         byte_done;

  assign byte_done = scl_fall && (bit_cnt_reg == ees_pkg::BYTE_BITS);

  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      // R14 standby after power-up
      state_reg        <= ees_pkg::ST_IDLE;
      phase_reg        <= ees_pkg::PH_DEV;
      bit_cnt_reg      <= '0;
      shift_reg        <= '0;
      addr_reg         <= '0;
      rnw_reg          <= 1'b0;
      pull_reg         <= 1'b0;
      wr_pend_reg      <= 1'b0;
      rd_req_tgl_reg   <= 1'b0;
      rd_addr_hold_reg <= '0;
      ev_tgl_reg       <= 1'b0;
      ev_hold_reg      <= '0;
    end else if (start_det) begin
      // R08 repeated start restarts
      state_reg   <= ees_pkg::ST_RX;
      phase_reg   <= ees_pkg::PH_DEV;
      bit_cnt_reg <= '0;
      pull_reg    <= 1'b0;
    end else if (stop_det) begin
      // R14 stop to standby
      state_reg <= ees_pkg::ST_IDLE;
      pull_reg  <= 1'b0;
      if (wr_pend_reg) begin
        ev_hold_reg <= '{ees_pkg::EV_STOP, addr_reg, shift_reg};
        ev_tgl_reg  <= ~ev_tgl_reg;
        wr_pend_reg <= 1'b0;
      end
    end else begin
      unique case (state_reg)
        // R06 ignore until start
        ees_pkg::ST_IDLE: begin
        end
        ees_pkg::ST_RX: begin
          if (scl_rise) begin
            // R01 sample on rise
            // R02 msb first
            shift_reg   <= {shift_reg[6:0], filt_reg[SDA]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            unique case (phase_reg)
              ees_pkg::PH_DEV: begin
                // R21 ack on match
                // R23 busy refuses
                if (dev_match(shift_reg, cfg_s2_reg[1:0]) && !busy_l) begin
                  pull_reg  <= 1'b1;
                  state_reg <= ees_pkg::ST_RX_ACK;
                  // R19 top address bit
                  addr_reg[ees_pkg::MEM_AW-1] <= shift_reg[ees_pkg::DA_TOP];
                  // R20 direction bit
                  rnw_reg <= shift_reg[ees_pkg::DA_RNW];
                  if (shift_reg[ees_pkg::DA_RNW]) begin
                    rd_addr_hold_reg <= {shift_reg[ees_pkg::DA_TOP], addr_reg[7:0]};
                    rd_req_tgl_reg   <= ~rd_req_tgl_reg;
                  end
                end else begin
                  // R14 mismatch to standby
                  state_reg <= ees_pkg::ST_IDLE;
                end
              end
              ees_pkg::PH_WORD: begin
                // R22 low address byte
                addr_reg[7:0] <= shift_reg;
                pull_reg      <= 1'b1;
                state_reg     <= ees_pkg::ST_RX_ACK;
              end
              ees_pkg::PH_DATA: begin
                ev_hold_reg <= '{ees_pkg::EV_WRITE, addr_reg, shift_reg};
                ev_tgl_reg  <= ~ev_tgl_reg;
                // R24 page offset wraps
                addr_reg[ees_pkg::PAGE_AW-1:0] <= addr_reg[ees_pkg::PAGE_AW-1:0] + 4'h1;
                wr_pend_reg <= 1'b1;
                pull_reg    <= 1'b1;
                state_reg   <= ees_pkg::ST_RX_ACK;
              end
              default: state_reg <= ees_pkg::ST_IDLE;
            endcase
          end
        end
        ees_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            // R12 release after ninth
            pull_reg    <= 1'b0;
            bit_cnt_reg <= '0;
            if (phase_reg == ees_pkg::PH_DEV && rnw_reg) begin
              shift_reg <= rd_byte_reg;
              pull_reg  <= ~rd_byte_reg[7];
              addr_reg  <= addr_reg + 9'h001;
              state_reg <= ees_pkg::ST_TX;
            end else begin
              // R09 bytes unbounded
              state_reg <= ees_pkg::ST_RX;
              phase_reg <= (phase_reg == ees_pkg::PH_DEV) ? ees_pkg::PH_WORD : ees_pkg::PH_DATA;
            end
          end
        end
        ees_pkg::ST_TX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            // R11 sender releases
            pull_reg  <= 1'b0;
            state_reg <= ees_pkg::ST_TX_ACK;
          end else if (scl_fall) begin
            // R01 drive on fall
            // R04 change while SCL low
            pull_reg  <= ~shift_reg[6];
            shift_reg <= {shift_reg[6:0], 1'b1};
          end
        end
        ees_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            if (filt_reg[SDA]) begin
              // R13 nack ends read
              state_reg <= ees_pkg::ST_IDLE;
            end else begin
              rd_addr_hold_reg <= addr_reg;
              rd_req_tgl_reg   <= ~rd_req_tgl_reg;
            end
          end else if (scl_fall) begin
            bit_cnt_reg <= '0;
            shift_reg   <= rd_byte_reg;
            pull_reg    <= ~rd_byte_reg[7];
            addr_reg    <= addr_reg + 9'h001;
            state_reg   <= ees_pkg::ST_TX;
          end
        end
        default: state_reg <= ees_pkg::ST_IDLE;
      endcase
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = ~pull_reg;

  // Idle flag from a flop so that nothing glitchy crosses domains
  logic idle_reg;

  // R14 standby flag
  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      idle_reg <= 1'b1;
    end else begin
      idle_reg <= (state_reg == ees_pkg::ST_IDLE);
    end
  end

  // ----------------------------------------
  // Read data return, link side
  // ----------------------------------------
  logic [2:0] rack_s_reg;
  logic       rd_ack_tgl_reg;
  logic [7:0] rd_data_reg;

  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      rack_s_reg  <= '0;
      rd_byte_reg <= '0;
    end else begin
      rack_s_reg <= {rack_s_reg[1:0], rd_ack_tgl_reg};
      if (rack_s_reg[2] != rack_s_reg[1]) begin
        rd_byte_reg <= rd_data_reg;
      end
    end
  end

  // ----------------------------------------
  // System side crossings
  // ----------------------------------------
  logic [2:0] ev_s_reg;
  logic [2:0] rreq_s_reg;
  logic [1:0] stby_s_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ev_s_reg   <= '0;
      rreq_s_reg <= '0;
      stby_s_reg <= '1;
    end else begin
      ev_s_reg   <= {ev_s_reg[1:0], ev_tgl_reg};
      rreq_s_reg <= {rreq_s_reg[1:0], rd_req_tgl_reg};
      stby_s_reg <= {stby_s_reg[0], idle_reg};
    end
  end

  assign standby = stby_s_reg[1];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ev_valid <= 1'b0;
      ev       <= '0;
    end else begin
      ev_valid <= ev_s_reg[2] != ev_s_reg[1];
      if (ev_s_reg[2] != ev_s_reg[1]) begin
        ev <= ev_hold_reg;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_rd_en      <= 1'b0;
      mem_rd_addr    <= '0;
      rd_data_reg    <= '0;
      rd_ack_tgl_reg <= 1'b0;
    end else begin
      mem_rd_en <= rreq_s_reg[2] != rreq_s_reg[1];
      if (rreq_s_reg[2] != rreq_s_reg[1]) begin
        mem_rd_addr <= rd_addr_hold_reg;
      end
      if (mem_rd_en) begin
        rd_data_reg    <= mem_rd_data;
        rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_link); endclocking
  default disable iff (!nrst);

  sequence s_rx_byte_done;
    state_reg == ees_pkg::ST_RX && byte_done && !start_det && !stop_det;
  endsequence

  sequence s_nack_seen;
    state_reg == ees_pkg::ST_TX_ACK && scl_rise && filt_reg[SDA] && !start_det && !stop_det;
  endsequence

  chk_sda_on_fall: assert property ( // R01
    (pull_reg != $past(pull_reg)) |-> $past(scl_fall || start_det || stop_det))
    else $error("SDA drive changed away from an SCL fall");

  chk_start_wakes: assert property ( // R05
    start_det |=> state_reg == ees_pkg::ST_RX && bit_cnt_reg == 4'h0 && !pull_reg)
    else $error("Start did not open a new byte");

  chk_idle_silent: assert property ( // R06
    state_reg == ees_pkg::ST_IDLE && !start_det |=> state_reg == ees_pkg::ST_IDLE && !pull_reg)
    else $error("Activity without a start");

  chk_stop_ends: assert property ( // R07
    stop_det && !start_det |=> state_reg == ees_pkg::ST_IDLE && !pull_reg)
    else $error("Stop did not end the transaction");

  chk_ack_holds: assert property ( // R11
    state_reg == ees_pkg::ST_RX_ACK |-> pull_reg)
    else $error("Ack not held low");

  chk_ack_release: assert property ( // R12
    state_reg == ees_pkg::ST_RX_ACK && scl_fall && !start_det && !stop_det &&
    !(phase_reg == ees_pkg::PH_DEV && rnw_reg) |=> !pull_reg)
    else $error("SDA kept after ninth clock");

  chk_nack_stops: assert property ( // R13
    s_nack_seen |=> state_reg == ees_pkg::ST_IDLE && !pull_reg)
    else $error("Transmission continued after NACK");

  chk_addr_refuse: assert property ( // R21
    s_rx_byte_done ##0 (phase_reg == ees_pkg::PH_DEV) ##0
    (!dev_match(shift_reg, cfg_s2_reg[1:0]) || busy_l) |=> state_reg == ees_pkg::ST_IDLE && !pull_reg)
    else $error("Address byte acknowledged without match");

  chk_page_wrap: assert property ( // R24
    s_rx_byte_done ##0 (phase_reg == ees_pkg::PH_DATA) |=>
    addr_reg[8:4] == $past(addr_reg[8:4]) && addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1)
    else $error("Write address left its page");

  chk_bit_count: assert property ( // R02
    bit_cnt_reg <= ees_pkg::BYTE_BITS)
    else $error("Bit counter passed eight");

endmodule : ees_slave

// ---- inc/ees_pkg.sv ----
/*
  Constants and types for the two-wire EEPROM slave interface.
  Assumes a consumer that stores written bytes and serves reads.
*/
package ees_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int unsigned PAGES      = 32;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned MEM_AW     = 9;
  localparam int unsigned PAGE_AW    = 4;

  // ----------------------------------------
  // Device address byte fields
  // ----------------------------------------
  localparam int unsigned DA_ID_HI    = 7;
  localparam int unsigned DA_ID_LO    = 4;
  localparam int unsigned DA_STRAP_HI = 3;
  localparam int unsigned DA_STRAP_LO = 2;
  localparam int unsigned DA_TOP      = 1;
  localparam int unsigned DA_RNW      = 0;

  // ----------------------------------------
  // Line indices, counts and reset values
  // ----------------------------------------
  localparam int unsigned LN_SCL       = 0;
  localparam int unsigned LN_SDA       = 1;
  localparam logic [1:0]  LINES_IDLE   = 2'h3;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam int unsigned FILT_LEN_DEF = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} ees_state_e;
  typedef enum logic [1:0] {PH_DEV, PH_WORD, PH_DATA} ees_phase_e;
  typedef enum logic {EV_WRITE, EV_STOP} ees_ev_e;

  typedef struct packed {
    ees_ev_e           kind;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        data;
  } ees_ev_s;

endpackage : ees_pkg

// ---- verif/ees_master_model.sv ----
/*
  Two-wire bus master model: drives SCL and pulls SDA low.
  Assumes the bench resolves SDA from all pull-downs with a pull-up.
*/
`timescale 1ns/1ps
module ees_master_model #(
  parameter int HALF_NS = 1000
) (
  // Bus lines
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // ----------------------------------------
  // Bus idle
  // ----------------------------------------
  // idle both high
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // ----------------------------------------
  // Bit and condition tasks
  // ----------------------------------------
  // SDA set in SCL low
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    #(HALF_NS/4);
    sda_pull = !b;
    #(HALF_NS*3/4);
    scl = 1'b1;
    #(HALF_NS/2);
    s = sda;
    #(HALF_NS/2);
    scl = 1'b0;
  endtask : bit_io

  task automatic start_c;
    #(HALF_NS/4);
    sda_pull = 1'b0;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_pull = 1'b1;
    #(HALF_NS);
    scl = 1'b0;
  endtask : start_c

  task automatic stop_c;
    #(HALF_NS/4);
    sda_pull = 1'b1;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_pull = 1'b0;
    #(HALF_NS);
  endtask : stop_c

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack);
  endtask : send_byte

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(!ack, s);
  endtask : recv_byte

  task automatic recover;
    logic s;
    start_c();
    for (int i = 0; i < 9; i++) begin
      bit_io(1'b1, s);
    end
    start_c();
    stop_c();
  endtask : recover
endmodule : ees_master_model

// ---- verif/ees_slave_tb.sv ----
/*
  Self-checking bench for the two-wire EEPROM slave front end.
  Assumes ees_pkg, ees_slave and ees_master_model compiled first.
*/
`timescale 1ns/1ps
module ees_slave_tb;
  localparam int         HALF_NS = 1000;
  // Arbitrary type identifier
  localparam logic [3:0] TYPE_ID = 4'h6;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic             clk_sys, clk_link, nrst, scl, sda_pull, sda_w, sda_o, sda_oe_n;
  logic             strap_hi, strap_lo, wr_busy, ev_valid, mem_rd_en, standby, ack;
  logic [8:0]       mem_rd_addr;
  logic [7:0]       mem_rd_data, rd;
  ees_pkg::ees_ev_s ev;
  ees_pkg::ees_ev_s evq[$];
  int               error_cnt = 0;
  int               num_checks = 0;

  assign sda_w = (sda_oe_n === 1'b0) ? (sda_o & !sda_pull) : !sda_pull;

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = !clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #24 clk_link = !clk_link;
  end

  ees_slave #(.FILT_LEN(3), .DEV_TYPE_ID(TYPE_ID)) DUT (
    .clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .strap_addr_hi(strap_hi), .strap_addr_lo(strap_lo),
    .wr_busy(wr_busy), .ev_valid(ev_valid), .ev(ev), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .standby(standby));
  ees_master_model #(.HALF_NS(HALF_NS)) u_mst (.scl(scl), .sda_pull(sda_pull), .sda(sda_w));

  // ----------------------------------------
  // Memory model and monitors
  // ----------------------------------------
  function automatic logic [7:0] pat(input logic [8:0] a);
    return a[7:0] ^ {8{a[8]}} ^ 8'h3C;
  endfunction : pat

  // Read data must stand while mem_rd_en is high, before the next edge
  always @(posedge clk_sys) begin
    #1;
    if (mem_rd_en === 1'b1) mem_rd_data = pat(mem_rd_addr);
  end

  always @(posedge clk_sys) begin
    if (ev_valid === 1'b1) evq.push_back(ev);
  end

  // Device drive may only move while SCL is low
  always @(sda_oe_n) if (nrst === 1'b1) chk_bit("drive edge scl", 1'b0, scl);

  // ----------------------------------------
  // Compare and helper tasks
  // ----------------------------------------
  task automatic chk_bit(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b got %b", what, e, g);
    end
  endtask : chk_bit

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask : chk_byte

  task automatic chk_ev(input ees_pkg::ees_ev_e k, input logic [8:0] a, input logic [7:0] d);
    ees_pkg::ees_ev_s g;
    num_checks++;
    g = 'x;
    if (evq.size() > 0) g = evq.pop_front();
    if (g.kind !== k || (k == ees_pkg::EV_WRITE && (g.addr !== a || g.data !== d))) begin
      error_cnt++;
      $display("CHECK FAILED event exp %b %h %h got %b %h %h", k, a, d, g.kind, g.addr, g.data);
    end
  endtask : chk_ev

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic probe(input logic [7:0] dev, input logic exp_ack, input string what);
    u_mst.start_c();
    u_mst.send_byte(dev, ack);
    u_mst.stop_c();
    chk_bit(what, !exp_ack, ack);
  endtask : probe

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    nrst        = 1'b0;
    strap_hi    = 1'b1;
    strap_lo    = 1'b0;
    wr_busy     = 1'b0;
    mem_rd_data = 8'h00;
    repeat (5) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    repeat (4) tick();
    chk_bit("standby after reset", 1'b1, standby);
    chk_bit("sda released", 1'b1, sda_oe_n);
    u_mst.send_byte({TYPE_ID, 4'b1000}, ack);
    chk_bit("ack without start", 1'b1, ack);
    for (int s = 0; s < 4; s++) begin
      tick();
      strap_hi = s[1];
      strap_lo = s[0];
      probe({TYPE_ID, s[1:0], 2'b00}, 1'b1, "strap match");
      probe({TYPE_ID, ~s[1:0], 2'b10}, 1'b0, "strap mismatch");
      probe({~TYPE_ID, s[1:0], 2'b00}, 1'b0, "type mismatch");
      chk_bit("standby after mismatch", 1'b1, standby);
    end
    // Page write from two short of the page end
    u_mst.start_c();
    u_mst.send_byte({TYPE_ID, strap_hi, strap_lo, 2'b10}, ack);
    chk_bit("dev ack", 1'b0, ack);
    chk_bit("awake", 1'b0, standby);
    u_mst.send_byte(8'h0E, ack);
    chk_bit("word ack", 1'b0, ack);
    for (int i = 0; i < 3; i++) begin
      u_mst.send_byte(8'h5C + i[7:0], ack);
      chk_bit("data ack", 1'b0, ack);
    end
    u_mst.stop_c();
    repeat (10) tick();
    for (int i = 0; i < 3; i++) begin
      chk_ev(ees_pkg::EV_WRITE, {5'h10, 4'hE + i[3:0]}, 8'h5C + i[7:0]);
    end
    chk_ev(ees_pkg::EV_STOP, 9'h000, 8'h00);
    wr_busy = 1'b1;
    probe({TYPE_ID, strap_hi, strap_lo, 2'b00}, 1'b0, "busy poll");
    tick();
    wr_busy = 1'b0;
    probe({TYPE_ID, strap_hi, strap_lo, 2'b00}, 1'b1, "poll after write");
    // Random read across the top of the array
    u_mst.start_c();
    u_mst.send_byte({TYPE_ID, strap_hi, strap_lo, 2'b10}, ack);
    u_mst.send_byte(8'hFF, ack);
    u_mst.start_c();
    u_mst.send_byte({TYPE_ID, strap_hi, strap_lo, 2'b11}, ack);
    chk_bit("read dev ack", 1'b0, ack);
    u_mst.recv_byte(1'b1, rd);
    chk_byte("read 1FF", pat(9'h1FF), rd);
    u_mst.recv_byte(1'b0, rd);
    chk_byte("read 000", pat(9'h000), rd);
    #(HALF_NS);
    chk_bit("release after nack", 1'b1, sda_oe_n);
    chk_bit("standby after nack", 1'b1, standby);
    u_mst.stop_c();
    u_mst.recover();
    probe({TYPE_ID, strap_hi, strap_lo, 2'b00}, 1'b1, "ack after recovery");
    chk_bit("no stray events", 1'b1, evq.size() == 0);
    print_verdict();
  end

  initial begin
    #(2_000_000);
    error_cnt++;
    print_verdict();
  end
endmodule : ees_slave_tb
